// [verilog/iodr_pkg.sv]
/*
 * iodr_pkg: shared types and constants for the per-pin output and
 * tri-state register path of an I/O cell.
 * Assumes one core clock; configuration is static or changes only
 * while the pad output is not in use.
 */
package iodr_pkg;

    typedef enum logic {
        IODR_MODE_SDR,
        IODR_MODE_DDR
    } iodr_mode_e;

    typedef enum logic {
        IODR_STORE_FLOP,
        IODR_STORE_LATCH
    } iodr_store_e;

    // configuration of one output cell
    typedef struct packed {
        iodr_mode_e mode;
        iodr_store_e store;
    } iodr_cfg_s;

    // values presented by core logic each cycle
    typedef struct packed {
        logic firstDataIn;
        logic secondDataIn;
        logic tristateCtrlIn;
    } iodr_core_s;

    // towards the pad output buffer
    typedef struct packed {
        logic data;
        logic oe;
    } iodr_pad_s;

    // reset values of the held bits
    localparam logic IODR_DATA_RST = 1'h0;
    localparam logic IODR_TRI_RST = 1'h1;
    localparam iodr_mode_e IODR_MODE_RST = IODR_MODE_SDR;
    localparam iodr_store_e IODR_STORE_RST = IODR_STORE_FLOP;

    // tristate control polarity: high floats the pad
    localparam logic IODR_TRI_FLOAT = 1'h1;

endpackage

// [verilog/iodr_fall_hold.sv]
/*
 * iodr_fall_hold: the two storage elements of the output path that do
 * not run on the rising edge: the fall-phase register and the SDR latch.
 * Assumes clk is the same output clock used by the rising-edge stage,
 * and that its inputs come from flip-flops on that clock.
 */
`timescale 1ns/1ps

module iodr_fall_hold (
    input wire logic clk,
    input wire logic rstn,
    input wire logic secondCaptured,
    input wire logic firstDataIn,
    output logic fallPhaseReg,
    output logic latchOut
);

    // negedge flop: second value already caught on the rise, held half a cycle later
    always_ff @(negedge clk or negedge rstn) begin
        if (!rstn) begin
            fallPhaseReg <= iodr_pkg::IODR_DATA_RST;
        end else begin
            fallPhaseReg <= secondCaptured;
        end
    end

    // transparent while clk high; data must be stable around the fall
    always_latch begin
        if (!rstn) begin
            latchOut = iodr_pkg::IODR_DATA_RST;
        end else if (clk) begin
            latchOut = firstDataIn;
        end
    end

endmodule // iodr_fall_hold

// [verilog/iodr_output_cell.sv]
/*
 * iodr_output_cell: output and tri-state register block of one pad
 * cell. Registers data and output enable from the core before the
 * pad buffer, in single or double data rate.
 * Assumes core inputs are launched on clk, configuration is quasi
 * static, and the pad buffer drives while oe is high.
 */
// Notes on behaviour
// - every data value from the core passes a storage element before the pad buffer.
// - in single rate the first data input goes into one storage element that drives the pad.
// - the single rate storage element is either an edge flop or a level latch by configuration.
// - in double rate both data inputs are captured into separate registers on every rising edge.
// - on the following falling edge the captured second value moves into the fall-phase register.
// - a mux driven by the output clock alternates the pad between rise and fall registers.
// - tristate control from the core is registered before the pad buffer, one register for SDR.
// - in single rate the tristate input feeds one flop whose output drives the output enable.
`timescale 1ns/1ps

module iodr_output_cell (
    input wire logic clk,
    input wire logic rstn,
    input wire iodr_pkg::iodr_cfg_s cfg,
    input wire iodr_pkg::iodr_core_s core,
    output iodr_pkg::iodr_pad_s pad
);

    // taken config plus every rising-edge storage element
    typedef struct packed {
        iodr_pkg::iodr_mode_e mode;
        iodr_pkg::iodr_store_e store;
        logic riseData;
        logic secondCap;
        logic sdrData;
        logic triCtrl;
    } iodr_state_s;

    // reset image: floating, single rate flop, so the pad stays quiet
    localparam iodr_state_s STATE_RST = '{
        mode: iodr_pkg::IODR_MODE_RST,
        store: iodr_pkg::IODR_STORE_RST,
        riseData: iodr_pkg::IODR_DATA_RST,
        secondCap: iodr_pkg::IODR_DATA_RST,
        sdrData: iodr_pkg::IODR_DATA_RST,
        triCtrl: iodr_pkg::IODR_TRI_RST
    };

    iodr_state_s state_r;
    iodr_state_s state_nxt;
    logic fallPhase;
    logic sdrLatch;
    logic ddrActive;
    logic latchActive;
    logic flopData;
    logic ddrData;
    logic padData;
    logic padOe;

    // double rate is chosen by the mode taken on the last edge
    function automatic logic modeIsDdr(input iodr_pkg::iodr_mode_e mode);
        return mode == iodr_pkg::IODR_MODE_DDR;
    endfunction

    // store choice only counts in single rate
    function automatic logic storeIsLatch(
        input iodr_pkg::iodr_mode_e mode,
        input iodr_pkg::iodr_store_e store
    );
        return !modeIsDdr(mode) && store == iodr_pkg::IODR_STORE_LATCH;
    endfunction

    // clock-driven half-cycle select
    function automatic logic halfSel(input logic phase, input logic hiVal, input logic loVal);
        return phase ? hiVal : loVal;
    endfunction

    // active-high enable from the float-polarity control
    function automatic logic driveFromTri(input logic triVal);
        return triVal != iodr_pkg::IODR_TRI_FLOAT;
    endfunction

    // config taken on the edge so the pad select never flips mid-cycle
    function automatic iodr_state_s takeConfig(
        input iodr_state_s cur,
        input iodr_pkg::iodr_cfg_s c
    );
        iodr_state_s n;
        n = cur;
        n.mode = c.mode;
        n.store = c.store;
        return n;
    endfunction

    // single rate flop stage
    function automatic iodr_state_s takeSdr(
        input iodr_state_s cur,
        input iodr_pkg::iodr_core_s c
    );
        iodr_state_s n;
        n = cur;
        n.sdrData = c.firstDataIn;
        return n;
    endfunction

    // both halves captured every edge whatever the mode, so a switch into
    // double rate shows fresh data from its first cycle
    function automatic iodr_state_s takeDdr(
        input iodr_state_s cur,
        input iodr_pkg::iodr_core_s c
    );
        iodr_state_s n;
        n = cur;
        n.riseData = c.firstDataIn;
        n.secondCap = c.secondDataIn;
        return n;
    endfunction

    // tristate control gets one flop, in single and double rate alike
    function automatic iodr_state_s takeTri(
        input iodr_state_s cur,
        input iodr_pkg::iodr_core_s c
    );
        iodr_state_s n;
        n = cur;
        n.triCtrl = c.tristateCtrlIn;
        return n;
    endfunction

    // whole rising-edge stage
    function automatic iodr_state_s nextState(
        input iodr_state_s cur,
        input iodr_pkg::iodr_cfg_s c,
        input iodr_pkg::iodr_core_s d
    );
        iodr_state_s n;
        n = takeConfig(cur, c);
        n = takeSdr(n, d);
        n = takeDdr(n, d);
        n = takeTri(n, d);
        return n;
    endfunction

    // single rate output: the flop, or the latch when so configured;
    // the latch follows the core while clk is high, so the core must
    // settle well before the fall
    function automatic logic sdrPick(
        input logic useLatch,
        input logic flopVal,
        input logic latchVal
    );
        logic v;
        if (useLatch) begin
            v = latchVal;
        end else begin
            v = flopVal;
        end
        return v;
    endfunction

    // double rate overrides the single rate choice once its mode is taken
    function automatic logic padPick(
        input logic useDdr,
        input logic sdrVal,
        input logic ddrVal
    );
        logic v;
        if (useDdr) begin
            v = ddrVal;
        end else begin
            v = sdrVal;
        end
        return v;
    endfunction

    // falling-edge register and latch live apart to keep one edge per process
    iodr_fall_hold uHold (
        .clk(clk),
        .rstn(rstn),
        .secondCaptured(state_r.secondCap),
        .firstDataIn(core.firstDataIn),
        .fallPhaseReg(fallPhase),
        .latchOut(sdrLatch)
    );

    // next value of every rising-edge element
    always_comb begin
        state_nxt = nextState(state_r, cfg, core);
    end

    // async reset falls back to the single rate flop, floating
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= STATE_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    // decode of the taken config
    always_comb begin
        ddrActive = modeIsDdr(state_r.mode);
        latchActive = storeIsLatch(state_r.mode, state_r.store);
    end

    // candidate values of each path
    always_comb begin
        flopData = sdrPick(latchActive, state_r.sdrData, sdrLatch);
        ddrData = halfSel(clk, state_r.riseData, fallPhase);
    end

    // pad mux; glitch-free only if clk and flop outputs settle together
    always_comb begin
        padData = padPick(ddrActive, flopData, ddrData);
        padOe = driveFromTri(state_r.triCtrl);
    end

    // towards the pad buffer
    always_comb begin
        pad.data = padData;
        pad.oe = padOe;
    end

endmodule // iodr_output_cell

// [tb/iodr_pad_model.sv]
/* iodr_pad_model: pad buffer seen from outside the cell.
   assumes oe high means the cell drives the pad. */
`timescale 1ns/1ps
module iodr_pad_model (
    input wire iodr_pkg::iodr_pad_s pad,
    output logic padLevel
);
    // released pad is pulled low, never left at the last value
    assign padLevel = pad.oe ? pad.data : 1'h0;
endmodule // iodr_pad_model

// [tb/iodr_output_cell_props.sv]
/* iodr_output_cell_props: timing checks on the pad outputs.
   assumes cfg held for two rising edges before a check applies. */
`timescale 1ns/1ps
module iodr_output_cell_props (
    input wire logic clk,
    input wire logic rstn,
    input wire iodr_pkg::iodr_cfg_s cfg,
    input wire iodr_pkg::iodr_core_s core,
    input wire iodr_pkg::iodr_pad_s pad
);
    logic live_r;
    iodr_pkg::iodr_cfg_s cfgA_r;
    iodr_pkg::iodr_cfg_s cfgB_r;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            live_r <= 1'h0;
            cfgA_r <= 2'h0;
            cfgB_r <= 2'h0;
        end else begin
            live_r <= 1'h1;
            cfgA_r <= cfg;
            cfgB_r <= cfgA_r;
        end
    end
    // mode switches land one edge late, so skip two edges
    wire logic settled = live_r && cfg == cfgA_r && cfg == cfgB_r;
    wire logic isFlop = settled && cfg == 2'h0;
    wire logic isLatch = settled && cfg == 2'h1;
    wire logic isDdr = settled && cfg[1];
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    chk_flop_data: assert property (isFlop |-> pad.data == $past(core.firstDataIn))
        else $error("flop data wrong");
    chk_flop_mid: assert property (@(negedge clk) isFlop |-> pad.data == $past(core.firstDataIn))
        else $error("flop data moved mid cycle");
    chk_latch_open: assert property (@(negedge clk) isLatch |-> pad.data == core.firstDataIn)
        else $error("latch not transparent");
    chk_latch_hold: assert property (isLatch |-> pad.data == core.firstDataIn)
        else $error("latch did not hold");
    chk_ddr_fall: assert property (isDdr |-> pad.data == $past(core.secondDataIn))
        else $error("fall phase wrong");
    chk_ddr_rise: assert property (@(negedge clk) isDdr |-> pad.data == $past(core.firstDataIn))
        else $error("rise phase wrong");
    chk_oe_reg: assert property (live_r |-> pad.oe == !$past(core.tristateCtrlIn))
        else $error("oe wrong");
    chk_oe_mid: assert property (@(negedge clk) live_r |-> pad.oe == !$past(core.tristateCtrlIn))
        else $error("oe moved mid cycle");
endmodule // iodr_output_cell_props
bind iodr_output_cell iodr_output_cell_props u_props (.clk(clk), .rstn(rstn), .cfg(cfg),
    .core(core), .pad(pad));

// [tb/iodr_output_cell_tb.sv]
/* iodr_output_cell_tb: random core traffic in every mode, checked
   against a reference model each half cycle; assumes an 8 ns clock. */
`timescale 1ns/1ps
module iodr_output_cell_tb;
    logic clk = 1'h0;
    logic rstn = 1'h0;
    iodr_pkg::iodr_cfg_s cfg = 2'h0;
    iodr_pkg::iodr_core_s core = 3'h0;
    iodr_pkg::iodr_core_s cap = 3'h0;
    iodr_pkg::iodr_core_s sent[$];
    iodr_pkg::iodr_pad_s pad;
    logic padLevel;
    int errors = 0;
    int n_tests = 0;
    int cyc = 0;
    always #4 clk = ~clk;
    iodr_output_cell u_dut (.clk(clk), .rstn(rstn), .cfg(cfg), .core(core), .pad(pad));
    iodr_pad_model u_pad (.pad(pad), .padLevel(padLevel));
    task automatic cmp(input logic [2:0] got, input logic [2:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        if (errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic d);
        cmp({pad, padLevel}, {d, !cap.tristateCtrlIn, d & !cap.tristateCtrlIn});
    endtask
    // one clock: new random inputs, then check high and low halves
    task automatic step(input iodr_pkg::iodr_cfg_s c, input bit on);
        logic hi;
        logic lo;
        iodr_pkg::iodr_core_s nxt;
        @(posedge clk);
        cap = sent.pop_front();
        nxt = 3'($urandom);
        sent.push_back(nxt);
        cfg <= c;
        core <= nxt;
        #2;
        hi = cfg == 2'h1 ? nxt.firstDataIn : cap.firstDataIn;
        lo = cfg[1] ? cap.secondDataIn : hi;
        if (on) chk(hi);
        @(negedge clk);
        #2;
        if (on) chk(lo);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc > 1000) begin
            errors++;
            close_out;
        end
    end
    initial begin
        iodr_pkg::iodr_cfg_s modes [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
        void'($urandom(95));
        sent.push_back(core);
        repeat (6) @(posedge clk);
        cmp({pad, padLevel}, 3'h0);
        rstn <= 1'h1;
        foreach (modes[m])
            for (int i = 0; i < 40; i++)
                step(modes[m], i > 2);
        close_out;
    end
endmodule // iodr_output_cell_tb
